// file: rtl/gps_pkg.sv
// constants and helpers for the gain and pulse source configuration bank
package gps_pkg;

   // register indices; byte address is four times the index
   localparam logic [15:0] CMP_MODE_IDX  = 16'hE60E;
   localparam logic [15:0] GAIN_CFG_IDX  = 16'hE60F;
   localparam logic [15:0] PULSE_CFG_IDX = 16'hE610;

   // reset values
   localparam logic [15:0] CMP_MODE_RST  = 16'h01FF;
   localparam logic [15:0] GAIN_CFG_RST  = 16'h0000;
   localparam logic [5:0]  PULSE_CFG_RST = 6'h08;

   // gain register fields
   localparam int PH_GAIN_LSB  = 0;
   localparam int NEU_GAIN_LSB = 3;
   localparam int VLT_GAIN_LSB = 6;

   // pulse register fields
   localparam int P1_SRC_LSB = 0;
   localparam int P2_SRC_LSB = 3;

   // computation mode fields
   localparam int P1_INC_LSB = 0;
   localparam int P2_INC_LSB = 3;

   // gain codes
   localparam logic [2:0] GAIN_CODE_MAX = 3'h4;
   localparam logic [4:0] GAIN_UNITY    = 5'h01;

   // pulse source codes
   localparam logic [2:0] SRC_TOT_ACT  = 3'h0;
   localparam logic [2:0] SRC_TOT_REA  = 3'h1;
   localparam logic [2:0] SRC_APPARENT = 3'h2;
   localparam logic [2:0] SRC_FUN_ACT  = 3'h3;
   localparam logic [2:0] SRC_FUN_REA  = 3'h4;

   // register select codes
   localparam logic [1:0] SEL_NONE  = 2'h0;
   localparam logic [1:0] SEL_CMP   = 2'h1;
   localparam logic [1:0] SEL_GAIN  = 2'h2;
   localparam logic [1:0] SEL_PULSE = 2'h3;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // reserved codes act as unity gain
   function automatic logic [4:0] gps_gain(input logic [2:0] code);
      gps_gain = (code <= GAIN_CODE_MAX) ? (GAIN_UNITY << code) : GAIN_UNITY;
   endfunction

endpackage

// file: rtl/gps_gain_decode.sv
// one gain-select field decoded to a registered gain factor
`timescale 1ns/10ps
`default_nettype none
module gps_gain_decode
   import gps_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic [2:0] code,
   output var  logic [4:0] gain_ff
);

   logic [4:0] nxt_gain;

   always_comb begin
      nxt_gain = gps_gain(code);
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         gain_ff <= GAIN_UNITY;
      end else begin
         gain_ff <= nxt_gain;
      end
   end

endmodule
`default_nettype wire

// file: rtl/gps_phase_sum.sv
// sums the chosen power quantity over the included phases
`timescale 1ns/10ps
`default_nettype none
module gps_phase_sum
   import gps_pkg::*;
#(
   parameter int PWR_W = 24,
   parameter int SUM_W = PWR_W + 2
) (
   input  wire logic                 clk,
   input  wire logic                 resetn,
   input  wire logic [2:0]           srcSel,
   input  wire logic [2:0]           phaseInc,
   input  wire logic [3*PWR_W-1:0]   totActive,
   input  wire logic [3*PWR_W-1:0]   totReactive,
   input  wire logic [3*PWR_W-1:0]   apparent,
   input  wire logic [3*PWR_W-1:0]   funActive,
   input  wire logic [3*PWR_W-1:0]   funReactive,
   output var  logic signed [SUM_W-1:0] sum_ff,
   output var  logic                 enable_ff
);

   logic [3*PWR_W-1:0]      pick;
   logic signed [SUM_W-1:0] acc;
   logic                    valid;

   always_comb begin
      pick  = '0;
      valid = 1'b1;
      case (srcSel)
         SRC_TOT_ACT:  pick = totActive;
         SRC_TOT_REA:  pick = totReactive;
         SRC_APPARENT: pick = apparent;
         SRC_FUN_ACT:  pick = funActive;
         SRC_FUN_REA:  pick = funReactive;
         default:      valid = 1'b0;
      endcase
      acc = '0;
      for (int i = 0; i < 3; i++) begin
         if (phaseInc[i] && valid) begin
            acc = acc + SUM_W'($signed(pick[i*PWR_W +: PWR_W]));
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         sum_ff    <= '0;
         enable_ff <= 1'b0;
      end else begin
         sum_ff    <= acc;
         enable_ff <= valid;
      end
   end

endmodule
`default_nettype wire

// file: rtl/gps_config_bank.sv
// gain and pulse source configuration bank behind an axi4-lite slave
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module gps_config_bank
   import gps_pkg::*;
#(
   parameter int ADDR_W      = 18,
   parameter int PWR_W       = 24,
   parameter bit HAS_NEUTRAL = 1'b1
) (
   input  wire logic                    clk,
   input  wire logic                    resetn,
   input  wire logic [ADDR_W-1:0]       awaddr,
   input  wire logic                    awvalid,
   output var  logic                    awready,
   input  wire logic [31:0]             wdata,
   input  wire logic [3:0]              wstrb,
   input  wire logic                    wvalid,
   output var  logic                    wready,
   output var  logic [1:0]              bresp,
   output var  logic                    bvalid,
   input  wire logic                    bready,
   input  wire logic [ADDR_W-1:0]       araddr,
   input  wire logic                    arvalid,
   output var  logic                    arready,
   output var  logic [31:0]             rdata,
   output var  logic [1:0]              rresp,
   output var  logic                    rvalid,
   input  wire logic                    rready,
   input  wire logic [3*PWR_W-1:0]      totActivePwr,
   input  wire logic [3*PWR_W-1:0]      totReactivePwr,
   input  wire logic [3*PWR_W-1:0]      apparentPwr,
   input  wire logic [3*PWR_W-1:0]      funActivePwr,
   input  wire logic [3*PWR_W-1:0]      funReactivePwr,
   output var  logic [4:0]              phaseCurrentGain,
   output var  logic [4:0]              neutralCurrentGain,
   output var  logic [4:0]              phaseVoltageGain,
   output var  logic [2:0]              pulse1Include,
   output var  logic [2:0]              pulse2Include,
   output var  logic signed [PWR_W+1:0] pulse1Sum,
   output var  logic signed [PWR_W+1:0] pulse2Sum,
   output var  logic                    pulse1Enable,
   output var  logic                    pulse2Enable
);

   localparam int SUM_W = PWR_W + 2;
   localparam logic [ADDR_W-1:0] CMP_ADDR   = ADDR_W'({CMP_MODE_IDX, 2'b00});
   localparam logic [ADDR_W-1:0] GAIN_ADDR  = ADDR_W'({GAIN_CFG_IDX, 2'b00});
   localparam logic [ADDR_W-1:0] PULSE_ADDR = ADDR_W'({PULSE_CFG_IDX, 2'b00});
   localparam logic [15:0] NEU_MASK = HAS_NEUTRAL ? 16'hFFFF : 16'hFFC7;

   typedef enum logic [3:0] {
      WR_IDLE = 4'b0001,
      WR_ADDR = 4'b0010,
      WR_DATA = 4'b0100,
      WR_RESP = 4'b1000
   } gps_wr_e;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_RESP = 2'b10
   } gps_rd_e;

   gps_wr_e             wrState_ff;
   gps_wr_e             nxt_wrState;
   gps_rd_e             rdState_ff;
   logic [ADDR_W-1:0]   wrAddrHold_ff;
   logic [15:0]         wrDataHold_ff;
   logic [1:0]          wrStrbHold_ff;
   logic                doWrite;
   logic [ADDR_W-1:0]   wrAddr;
   logic [15:0]         wrData;
   logic [1:0]          wrStrb;
   logic [1:0]          wrSel;
   logic [1:0]          bresp_ff;
   logic [31:0]         rdata_ff;
   logic [1:0]          rresp_ff;
   logic [15:0]         gainCfg_ff;
   logic [5:0]          pulseCfg_ff;
   logic [15:0]         computation_mode_reg_ff;
   logic [15:0]         rdWord;
   logic [1:0]          rdSel;

   // address to register select, shared by both channels
   function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] addr);
      if (addr == CMP_ADDR) begin
         reg_sel = SEL_CMP;
      end else if (addr == GAIN_ADDR) begin
         reg_sel = SEL_GAIN;
      end else if (addr == PULSE_ADDR) begin
         reg_sel = SEL_PULSE;
      end else begin
         reg_sel = SEL_NONE;
      end
   endfunction

   // byte-lane merge over the low two lanes
   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [15:0] data,
                                         input logic [1:0]  strb);
      merge = old;
      if (strb[0]) begin
         merge[7:0] = data[7:0];
      end
      if (strb[1]) begin
         merge[15:8] = data[15:8];
      end
   endfunction

   // write channel handshakes; address and data taken in either order
   assign awready = (wrState_ff == WR_IDLE) || (wrState_ff == WR_DATA);
   assign wready  = (wrState_ff == WR_IDLE) || (wrState_ff == WR_ADDR);
   assign bvalid  = (wrState_ff == WR_RESP);
   assign bresp   = bresp_ff;

   always_comb begin
      nxt_wrState = wrState_ff;
      doWrite     = 1'b0;
      wrAddr      = awaddr;
      wrData      = wdata[15:0];
      wrStrb      = wstrb[1:0];
      case (wrState_ff)
         WR_IDLE: begin
            if (awvalid && wvalid) begin
               doWrite     = 1'b1;
               nxt_wrState = WR_RESP;
            end else if (awvalid) begin
               nxt_wrState = WR_ADDR;
            end else if (wvalid) begin
               nxt_wrState = WR_DATA;
            end
         end
         WR_ADDR: begin
            wrAddr = wrAddrHold_ff;
            if (wvalid) begin
               doWrite     = 1'b1;
               nxt_wrState = WR_RESP;
            end
         end
         WR_DATA: begin
            wrData = wrDataHold_ff;
            wrStrb = wrStrbHold_ff;
            if (awvalid) begin
               doWrite     = 1'b1;
               nxt_wrState = WR_RESP;
            end
         end
         WR_RESP: begin
            if (bready) begin
               nxt_wrState = WR_IDLE;
            end
         end
         default: nxt_wrState = WR_IDLE;
      endcase
      wrSel = reg_sel(wrAddr);
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         wrState_ff <= WR_IDLE;
      end else begin
         wrState_ff <= nxt_wrState;
      end
   end

   // hold whichever half of a write arrived first
   always_ff @(posedge clk) begin
      if (!resetn) begin
         wrAddrHold_ff <= '0;
         wrDataHold_ff <= '0;
         wrStrbHold_ff <= '0;
      end else begin
         if (awvalid && awready) begin
            wrAddrHold_ff <= awaddr;
         end
         if (wvalid && wready) begin
            wrDataHold_ff <= wdata[15:0];
            wrStrbHold_ff <= wstrb[1:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         bresp_ff <= RESP_OKAY;
      end else if (doWrite) begin
         bresp_ff <= (wrSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
   end

   // configuration registers
   always_ff @(posedge clk) begin
      if (!resetn) begin
         gainCfg_ff <= GAIN_CFG_RST;
      end else if (doWrite && wrSel == SEL_GAIN) begin
         gainCfg_ff <= merge(gainCfg_ff, wrData, wrStrb) & NEU_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         pulseCfg_ff <= PULSE_CFG_RST;
      end else if (doWrite && wrSel == SEL_PULSE) begin
         pulseCfg_ff <= 6'(merge({10'h000, pulseCfg_ff}, wrData, wrStrb));
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         computation_mode_reg_ff <= CMP_MODE_RST;
      end else if (doWrite && wrSel == SEL_CMP) begin
         computation_mode_reg_ff <= merge(computation_mode_reg_ff, wrData, wrStrb);
      end
   end

   // read channel
   assign arready = (rdState_ff == RD_IDLE);
   assign rvalid  = (rdState_ff == RD_RESP);
   assign rdata   = rdata_ff;
   assign rresp   = rresp_ff;

   always_comb begin
      rdSel = reg_sel(araddr);
      if (rdSel == SEL_CMP) begin
         rdWord = computation_mode_reg_ff;
      end else if (rdSel == SEL_GAIN) begin
         rdWord = gainCfg_ff;
      end else if (rdSel == SEL_PULSE) begin
         rdWord = {10'h000, pulseCfg_ff};
      end else begin
         rdWord = 16'h0000;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdState_ff <= RD_IDLE;
         rdata_ff   <= 32'h00000000;
         rresp_ff   <= RESP_OKAY;
      end else begin
         case (rdState_ff)
            RD_IDLE: begin
               if (arvalid) begin
                  rdState_ff <= RD_RESP;
                  rdata_ff   <= {16'h0000, rdWord};
                  rresp_ff   <= (rdSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
               end
            end
            RD_RESP: begin
               if (rready) begin
                  rdState_ff <= RD_IDLE;
               end
            end
            default: rdState_ff <= RD_IDLE;
         endcase
      end
   end

   // gain decode; bits 15:9 feed nothing
   gps_gain_decode u_phGain (
      .clk     (clk),
      .resetn  (resetn),
      .code    (gainCfg_ff[PH_GAIN_LSB +: 3]),
      .gain_ff (phaseCurrentGain)
   );

   gps_gain_decode u_neuGain (
      .clk     (clk),
      .resetn  (resetn),
      .code    (gainCfg_ff[NEU_GAIN_LSB +: 3]),
      .gain_ff (neutralCurrentGain)
   );

   gps_gain_decode u_vltGain (
      .clk     (clk),
      .resetn  (resetn),
      .code    (gainCfg_ff[VLT_GAIN_LSB +: 3]),
      .gain_ff (phaseVoltageGain)
   );

   assign pulse1Include = computation_mode_reg_ff[P1_INC_LSB +: 3];
   assign pulse2Include = computation_mode_reg_ff[P2_INC_LSB +: 3];

   gps_phase_sum #(.PWR_W(PWR_W), .SUM_W(SUM_W)) u_p1Sum (
      .clk         (clk),
      .resetn      (resetn),
      .srcSel      (pulseCfg_ff[P1_SRC_LSB +: 3]),
      .phaseInc    (pulse1Include),
      .totActive   (totActivePwr),
      .totReactive (totReactivePwr),
      .apparent    (apparentPwr),
      .funActive   (funActivePwr),
      .funReactive (funReactivePwr),
      .sum_ff      (pulse1Sum),
      .enable_ff   (pulse1Enable)
   );

   gps_phase_sum #(.PWR_W(PWR_W), .SUM_W(SUM_W)) u_p2Sum (
      .clk         (clk),
      .resetn      (resetn),
      .srcSel      (pulseCfg_ff[P2_SRC_LSB +: 3]),
      .phaseInc    (pulse2Include),
      .totActive   (totActivePwr),
      .totReactive (totReactivePwr),
      .apparent    (apparentPwr),
      .funActive   (funActivePwr),
      .funReactive (funReactivePwr),
      .sum_ff      (pulse2Sum),
      .enable_ff   (pulse2Enable)
   );

   // checks
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence wrGainFull;
      doWrite && wrSel == SEL_GAIN && wrStrb == 2'h3;
   endsequence

   AST_PH_GAIN_LEGAL: assert property (
      gainCfg_ff[2:0] <= 3'h4 |=> phaseCurrentGain == (5'h01 << $past(gainCfg_ff[2:0])))
      else $error("phase current gain mismatch");

   AST_PH_GAIN_RSVD: assert property (
      gainCfg_ff[2:0] > 3'h4 |=> phaseCurrentGain == 5'h01)
      else $error("phase current reserved code not unity");

   AST_NEU_GAIN_LEGAL: assert property (
      gainCfg_ff[5:3] <= 3'h4 |=> neutralCurrentGain == (5'h01 << $past(gainCfg_ff[5:3])))
      else $error("neutral gain mismatch");

   AST_NEU_GAIN_RSVD: assert property (
      gainCfg_ff[5:3] > 3'h4 |=> neutralCurrentGain == 5'h01)
      else $error("neutral reserved code not unity");

   AST_NEU_ABSENT: assert property (
      !HAS_NEUTRAL |-> gainCfg_ff[5:3] == 3'h0 && neutralCurrentGain == 5'h01)
      else $error("neutral field not zero");

   AST_VLT_GAIN: assert property (
      gainCfg_ff[8:6] == 3'h4 |=> phaseVoltageGain == 5'h10)
      else $error("voltage gain code 4 not 16");

   AST_VLT_GAIN_RSVD: assert property (
      gainCfg_ff[8:6] > 3'h4 |=> phaseVoltageGain == 5'h01)
      else $error("voltage reserved code not unity");

   AST_RSVD_NO_EFFECT: assert property (
      $stable(gainCfg_ff[8:0]) && !$stable(gainCfg_ff[15:9])
      |=> $stable(phaseCurrentGain) && $stable(phaseVoltageGain))
      else $error("reserved gain bits changed a gain");

   AST_GAIN_WRITE: assert property (
      wrGainFull |=> bvalid && gainCfg_ff == ($past(wrData) & NEU_MASK)
      ##1 phaseCurrentGain == gps_gain(gainCfg_ff[2:0]))
      else $error("gain write not applied next cycle");

   AST_P1_TOT_ACT: assert property (
      pulseCfg_ff[2:0] == 3'h0 && pulse1Include == 3'h1
      |=> pulse1Sum == SUM_W'($signed($past(totActivePwr[PWR_W-1:0]))) && pulse1Enable)
      else $error("pulse one total active sum wrong");

   AST_P1_APPARENT: assert property (
      pulseCfg_ff[2:0] == 3'h2 && pulse1Include == 3'h2
      |=> pulse1Sum == SUM_W'($signed($past(apparentPwr[2*PWR_W-1:PWR_W]))))
      else $error("pulse one apparent sum wrong");

   AST_P1_FUN_ACT: assert property (
      pulseCfg_ff[2:0] == 3'h3 && pulse1Include == 3'h4
      |=> pulse1Sum == SUM_W'($signed($past(funActivePwr[3*PWR_W-1:2*PWR_W]))))
      else $error("pulse one fundamental active sum wrong");

   AST_P1_FUN_REA: assert property (
      pulseCfg_ff[2:0] == 3'h4 && pulse1Include == 3'h1
      |=> pulse1Sum == SUM_W'($signed($past(funReactivePwr[PWR_W-1:0]))))
      else $error("pulse one fundamental reactive sum wrong");

   AST_P2_MASK: assert property (
      pulse2Include == 3'h0 |=> pulse2Sum == '0)
      else $error("pulse two summed an excluded phase");

   AST_CMP_RESET: assert property (
      $rose(resetn) |-> computation_mode_reg_ff == 16'h01FF && pulse1Include == 3'h7)
      else $error("include bits not set after reset");

   AST_P2_OFF: assert property (
      pulseCfg_ff[5:3] > 3'h4 |=> !pulse2Enable && pulse2Sum == '0)
      else $error("pulse two active on reserved code");

endmodule
`default_nettype wire

// file: testbench/gps_config_bank_tb.sv
// self-checking bench for the gain and pulse source configuration bank
`timescale 1ns/10ps
`default_nettype none
module gps_config_bank_tb
   import gps_pkg::*;
;
   localparam logic [17:0] A_CMP   = {CMP_MODE_IDX, 2'b00};
   localparam logic [17:0] A_GAIN  = {GAIN_CFG_IDX, 2'b00};
   localparam logic [17:0] A_PULSE = {PULSE_CFG_IDX, 2'b00};

   logic          clk, resetn;
   logic [17:0]   awaddr, araddr;
   logic          awvalid, wvalid, bready, arvalid, rready;
   logic          awready, wready, bvalid, arready, rvalid;
   logic [31:0]   wdata, rdata;
   logic [3:0]    wstrb;
   logic [1:0]    bresp, rresp;
   logic [71:0]   pwr [5];
   logic [4:0]    phaseCurrentGain, neutralCurrentGain, phaseVoltageGain;
   logic [2:0]    pulse1Include, pulse2Include;
   logic [25:0]   pulse1Sum, pulse2Sum;
   logic          pulse1Enable, pulse2Enable;
   int            err_total, check_count;
   logic [31:0]   rdataNoNeu;
   logic [4:0]    neuGainNoNeu;

   gps_config_bank gps_config_bank_i (
      .clk(clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .totActivePwr(pwr[0]), .totReactivePwr(pwr[1]), .apparentPwr(pwr[2]),
      .funActivePwr(pwr[3]), .funReactivePwr(pwr[4]),
      .phaseCurrentGain(phaseCurrentGain), .neutralCurrentGain(neutralCurrentGain),
      .phaseVoltageGain(phaseVoltageGain), .pulse1Include(pulse1Include),
      .pulse2Include(pulse2Include), .pulse1Sum(pulse1Sum), .pulse2Sum(pulse2Sum),
      .pulse1Enable(pulse1Enable), .pulse2Enable(pulse2Enable));

   // variant without neutral input, driven in lockstep with the first
   gps_config_bank #(.HAS_NEUTRAL(1'b0)) gps_config_bank_noneu_i (
      .clk(clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid), .awready(),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(), .bresp(), .bvalid(),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(), .rdata(rdataNoNeu),
      .rresp(), .rvalid(), .rready(rready), .totActivePwr(pwr[0]),
      .totReactivePwr(pwr[1]), .apparentPwr(pwr[2]), .funActivePwr(pwr[3]),
      .funReactivePwr(pwr[4]), .phaseCurrentGain(), .neutralCurrentGain(neuGainNoNeu),
      .phaseVoltageGain(), .pulse1Include(), .pulse2Include(), .pulse1Sum(),
      .pulse2Sum(), .pulse1Enable(), .pulse2Enable());

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         err_total++;
      end
   endtask

   // power sample per quantity and phase, small and distinct
   function automatic logic [23:0] pv(input int q, input int ph);
      pv = 24'(16 * q + ph + 1);
   endfunction

   function automatic logic [4:0] gx(input int c);
      gx = (c <= 4) ? (5'h01 << c) : 5'h01;
   endfunction

   // expected sum of one quantity over the included phases
   function automatic logic [25:0] esum(input int c, input logic [2:0] m);
      esum = 26'h0;
      for (int ph = 0; ph < 3; ph++) begin
         if (m[ph] && c <= 4) begin
            esum = esum + 26'(pv(c, ph));
         end
      end
   endfunction

   task automatic axw(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
      logic ad;
      logic dd;
      ad = 1'b0;
      dd = 1'b0;
      r = 2'h1;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(posedge clk);
         if (!ad && awready) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (!dd && wready) begin
            dd = 1'b1;
            wvalid <= 1'b0;
         end
         if (bvalid) begin
            r = bresp;
            bready <= 1'b0;
            return;
         end
      end
      err_total++;
      complete_run();
   endtask

   task automatic axr(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(posedge clk);
         if (arvalid && arready) begin
            arvalid <= 1'b0;
         end
         if (rvalid) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            return;
         end
      end
      err_total++;
      complete_run();
   endtask

   task automatic wr_ok(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [1:0] r;
      axw(a, d, s, r);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
   endtask

   task automatic rd_chk(input logic [17:0] a, input logic [31:0] exp, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      axr(a, d, r);
      chk(d, exp);
      chk({30'h0, r}, {30'h0, er});
   endtask

   task automatic test_reset_values();
      rd_chk(A_CMP, 32'h0000_01FF, RESP_OKAY);
      rd_chk(A_GAIN, 32'h0000_0000, RESP_OKAY);
      rd_chk(A_PULSE, 32'h0000_0008, RESP_OKAY);
      chk({27'h0, phaseCurrentGain}, 32'h1);
      chk({26'h0, pulse1Include, pulse2Include}, 32'h3F);
   endtask

   task automatic test_gain_codes();
      for (int c = 0; c < 8; c++) begin
         wr_ok(A_GAIN, {23'h0, 3'(c), 3'(c), 3'(c)}, 4'hF);
         repeat (2) @(posedge clk);
         chk({27'h0, phaseCurrentGain}, {27'h0, gx(c)});
         chk({27'h0, neutralCurrentGain}, {27'h0, gx(c)});
         chk({27'h0, phaseVoltageGain}, {27'h0, gx(c)});
         chk({27'h0, neuGainNoNeu}, 32'h1);
      end
      // upper byte only: reserved bits written, field 8:6 becomes 3
      wr_ok(A_GAIN, 32'hFFFF_AA12, 4'h2);
      rd_chk(A_GAIN, 32'h0000_AAFF, RESP_OKAY);
      chk(rdataNoNeu, 32'h0000_AAC7);
      repeat (2) @(posedge clk);
      chk({27'h0, phaseVoltageGain}, 32'h8);
      chk({27'h0, phaseCurrentGain}, 32'h1);
      // only reserved bits 15:9 change, bit 8 kept
      wr_ok(A_GAIN, 32'h0000_5400, 4'h2);
      rd_chk(A_GAIN, 32'h0000_54FF, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk({27'h0, phaseVoltageGain}, 32'h8);
      chk({27'h0, phaseCurrentGain}, 32'h1);
   endtask

   task automatic test_pulse_sources();
      logic [2:0] m1 [4];
      logic [2:0] m2 [4];
      m1 = '{3'h5, 3'h1, 3'h2, 3'h4};
      m2 = '{3'h3, 3'h0, 3'h6, 3'h7};
      for (int k = 0; k < 4; k++) begin
         wr_ok(A_CMP, {26'h007, m2[k], m1[k]}, 4'hF);
         for (int c = 0; c < 8; c++) begin
            wr_ok(A_PULSE, {16'h0, 10'h3FF, 3'(c), 3'(c)}, 4'hF);
            rd_chk(A_PULSE, {26'h0, 3'(c), 3'(c)}, RESP_OKAY);
            repeat (3) @(posedge clk);
            chk({26'h0, pulse1Include, pulse2Include}, {26'h0, m1[k], m2[k]});
            chk({6'h0, pulse1Sum}, {6'h0, esum(c, m1[k])});
            chk({6'h0, pulse2Sum}, {6'h0, esum(c, m2[k])});
            chk({31'h0, pulse1Enable}, {31'h0, c <= 4});
            chk({31'h0, pulse2Enable}, {31'h0, c <= 4});
         end
      end
   endtask

   task automatic test_unmapped();
      logic [1:0] r;
      axw(18'h39844, 32'h0000_FFFF, 4'hF, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      axw(18'h3983D, 32'h0000_FFFF, 4'hF, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      rd_chk(18'h39844, 32'h0, RESP_SLVERR);
      rd_chk(A_GAIN, 32'h0000_54FF, RESP_OKAY);
   endtask

   initial begin
      err_total = 0;
      check_count = 0;
      resetn = 1'b0;
      awaddr = '0;
      araddr = '0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      wdata = '0;
      wstrb = '0;
      for (int q = 0; q < 5; q++) begin
         pwr[q] = {pv(q, 2), pv(q, 1), pv(q, 0)};
      end
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      test_reset_values();
      test_gain_codes();
      test_pulse_sources();
      test_unmapped();
      complete_run();
   end
endmodule
`default_nettype wire
